// >>> pvbs_sequencer.sv
// sink side power-on, black video and video status sequencer
module pvbs_sequencer
    import pvbs_pkg::*;
#(
    parameter int unsigned VALID_CYC = VALID_MAX_CYC - SYNC_SLACK,
    parameter int unsigned HPD_DLY_CYC = HPD_MAX_CYC - SYNC_SLACK
)
(
    input wire logic core_clk_i, // 20 MHz clock
    input wire logic sys_rst_i, // sync reset, high
    input wire logic panel_logic_supply_i, // supply good pin
    input wire logic black_disable_i, // debug pin, no auto black
    input wire logic video_valid_i, // link sees valid video
    input wire logic no_video_flag_i, // vb-id no-stream flag
    input wire logic link_idle_i, // idle or off signalling
    input pvbs_aux_req_s aux_req_i, // aux read request
    output pvbs_aux_rsp_s aux_rsp_o, // aux answer
    output logic hpd_o, // hot-plug detect
    output logic black_video_o // show black video
);
    logic supply_meta_reg;
    logic supply_s_reg;
    logic supply_q_reg;
    logic dbg_meta_reg;
    logic dbg_s_reg;
    pvbs_state_e state_reg;
    pvbs_state_e state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic status_reg;
    logic black_reg;
    logic hpd_reg;
    pvbs_aux_rsp_s rsp_reg;
    logic video_ok;
    logic boot_done;
    logic valid_done;

    assign video_ok = video_valid_i & ~no_video_flag_i & ~link_idle_i;
    assign boot_done = (cnt_reg == CNT_W'(HPD_DLY_CYC - 1));
    assign valid_done = (cnt_reg == CNT_W'(VALID_CYC - 1));

    // supply and debug pins pass two flops first; video status pins are used unsynchronised
    // third supply stage only feeds the boot edge check
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            supply_meta_reg <= 1'b0;
            supply_s_reg <= 1'b0;
            supply_q_reg <= 1'b0;
            dbg_meta_reg <= 1'b0;
            dbg_s_reg <= 1'b0;
        end
        else
        begin
            supply_meta_reg <= panel_logic_supply_i;
            supply_s_reg <= supply_meta_reg;
            supply_q_reg <= supply_s_reg;
            dbg_meta_reg <= black_disable_i;
            dbg_s_reg <= dbg_meta_reg;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        if (!supply_s_reg)
        begin
            state_next = ST_OFF;
        end
        else
        begin
            unique case (state_reg)
                ST_OFF: state_next = ST_BOOT;
                ST_BOOT:
                begin
                    if (boot_done)
                    begin
                        state_next = ST_BLACK;
                    end
                end
                ST_BLACK:
                begin
                    if (video_ok)
                    begin
                        state_next = ST_VALIDATE;
                    end
                end
                ST_VALIDATE:
                begin
                    // any glitch restarts validation, so a flaky link
                    // never reaches the panel
                    if (!video_ok)
                    begin
                        state_next = ST_BLACK;
                    end
                    else if (valid_done)
                    begin
                        state_next = ST_VIDEO;
                    end
                end
                ST_VIDEO:
                begin
                    if (!video_ok)
                    begin
                        state_next = ST_BLACK;
                    end
                end
                default: state_next = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= ST_OFF;
            cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            // counter runs free outside boot and validate; only
            // those states compare it, so a wrap is harmless
            if (state_next != state_reg)
            begin
                cnt_reg <= '0;
            end
            else
            begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

    // black unless video is validated or the debug pin is set; also while unpowered
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            black_reg <= RST_BLACK;
            status_reg <= RST_STATUS;
            hpd_reg <= RST_HPD;
        end
        else
        begin
            black_reg <= (state_next != ST_VIDEO) & ~dbg_s_reg;
            status_reg <= (state_next == ST_VIDEO);
            // hpd from next state, so it rises with entry to black
            hpd_reg <= (state_next == ST_BLACK)
                | (state_next == ST_VALIDATE)
                | (state_next == ST_VIDEO);
        end
    end

    // aux answer one cycle after request; defer until hpd is up
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg.ack <= aux_req_i.req & hpd_reg;
            rsp_reg.defer <= aux_req_i.req & ~hpd_reg;
            rsp_reg.data <= RD_ZERO;
            if (aux_req_i.req && hpd_reg
                && aux_req_i.addr == SINK_STATUS_ADDR)
            begin
                rsp_reg.data[SINK_VIDEO_BIT] <= status_reg;
            end
        end
    end

    assign aux_rsp_o = rsp_reg;
    assign hpd_o = hpd_reg;
    assign black_video_o = black_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_black_at_boot: assert property (
        supply_s_reg && !supply_q_reg && !dbg_s_reg |=> black_video_o)
        else $error("black video not on after supply up");
    a_validate_end: assert property (
        state_reg == ST_VALIDATE && valid_done && video_ok && supply_s_reg
        |=> status_reg && !black_video_o)
        else $error("validated video did not set status");
    a_video_end: assert property (
        state_reg == ST_VIDEO && supply_s_reg && !video_valid_i
        |=> !status_reg ##0 (black_video_o || $past(dbg_s_reg)))
        else $error("video end did not clear status");
    a_novideo_black: assert property (
        no_video_flag_i && !dbg_s_reg |=> black_video_o && !status_reg)
        else $error("no-video flag did not force black");
    a_debug_disable: assert property (
        dbg_s_reg && $past(dbg_s_reg) |-> !black_video_o)
        else $error("black shown while disabled");
    a_aux_defer: assert property (
        aux_req_i.req && !hpd_o |=> aux_rsp_o.defer && !aux_rsp_o.ack)
        else $error("early aux request not deferred");
    a_aux_answer: assert property (
        aux_req_i.req && hpd_o |=> aux_rsp_o.ack && !aux_rsp_o.defer)
        else $error("aux request not answered");
    a_status_read: assert property (
        aux_req_i.req && hpd_o && aux_req_i.addr == SINK_STATUS_ADDR
        |=> aux_rsp_o.data[SINK_VIDEO_BIT] == $past(status_reg))
        else $error("status read wrong");
    a_idle_black: assert property (
        link_idle_i && !dbg_s_reg |=> black_video_o)
        else $error("idle link not black");
    a_hpd_delay: assert property (
        $rose(hpd_o) |-> $past(boot_done) && $past(state_reg) == ST_BOOT)
        else $error("hpd rose at wrong time");

    c_video_on: cover property (state_reg == ST_VALIDATE ##1 status_reg);
    c_aux_defer: cover property (aux_rsp_o.defer);
    c_video_lost: cover property (status_reg ##1 !status_reg);
    // idle signalling and debug override paths
    c_idle_black: cover property (status_reg && link_idle_i ##1 black_video_o);
    c_debug_off: cover property (dbg_s_reg && !black_video_o);
endmodule : pvbs_sequencer

// >>> pvbs_pkg.sv
// constants and carrier types for the panel video sequencer
package pvbs_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned VALID_MAX_MS = 50;
    localparam int unsigned HPD_MAX_MS = 200;
    localparam int unsigned BLACK_MAX_MS = 200;
    localparam int unsigned VALID_MAX_CYC = VALID_MAX_MS * CYC_PER_MS;
    localparam int unsigned HPD_MAX_CYC = HPD_MAX_MS * CYC_PER_MS;
    localparam int unsigned BLACK_MAX_CYC = BLACK_MAX_MS * CYC_PER_MS;
    // synchroniser and register latency taken off the deadlines
    localparam int unsigned SYNC_SLACK = 4;
    localparam int unsigned CNT_W = 23;
    localparam int unsigned AUX_ADDR_W = 20;
    localparam logic [AUX_ADDR_W-1:0] SINK_STATUS_ADDR = 20'h00205;
    localparam int unsigned SINK_VIDEO_BIT = 0;
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic RST_BLACK = 1'b1;
    localparam logic RST_HPD = 1'b0;
    localparam logic RST_STATUS = 1'b0;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_BOOT = 5'h02,
        ST_BLACK = 5'h04,
        ST_VALIDATE = 5'h08,
        ST_VIDEO = 5'h10
    } pvbs_state_e;

    typedef struct packed {
        logic req;
        logic [AUX_ADDR_W-1:0] addr;
    } pvbs_aux_req_s;

    typedef struct packed {
        logic ack;
        logic defer;
        logic [7:0] data;
    } pvbs_aux_rsp_s;
endpackage : pvbs_pkg

// >>> pvbs_source_model.sv
// behavioural video source with backlight sequencing
module pvbs_source_model
#(
    parameter int unsigned GAP = 20000
)
(
    input wire logic core_clk_i, // bench clock
    input wire logic sys_rst_i, // sync reset, high
    input wire logic run_i, // panel on request
    output logic video_valid_o, // valid video
    output logic no_video_flag_o, // no-stream flag
    output logic link_idle_o, // idle signalling
    output logic bl_rail_o, // backlight rail
    output logic bl_dim_o, // dimming signal
    output logic bl_en_o // backlight enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] step_reg;
    int tmr_reg;
    // one step per gap: every backlight delay lasts at least gap cycles
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            step_reg <= 3'h0;
            tmr_reg <= 0;
        end
        else if (tmr_reg != 0)
            tmr_reg <= tmr_reg - 1;
        else if (run_i && step_reg != 3'h4)
        begin
            step_reg <= step_reg + 3'h1;
            tmr_reg <= GAP;
        end
        else if (!run_i && step_reg != 3'h0)
        begin
            step_reg <= step_reg - 3'h1;
            tmr_reg <= GAP;
        end
    end
    assign video_valid_o = step_reg != 3'h0;
    assign no_video_flag_o = step_reg == 3'h0;
    assign link_idle_o = step_reg == 3'h0;
    assign bl_rail_o = step_reg >= 3'h2;
    assign bl_dim_o = step_reg >= 3'h3;
    assign bl_en_o = step_reg == 3'h4;
endmodule : pvbs_source_model

// >>> tb_top.sv
// self-checking bench for the panel video sequencer
module tb_top
    import pvbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int VC = 20;
    localparam int HC = 16;
    localparam int GP = 24;
    logic clk, rst, sup, bdis, run, tflag, tidl, vv, nv, idl, en, hpd, blk;
    pvbs_aux_req_s req;
    pvbs_aux_rsp_s rsp;
    int n_mismatch = 0;
    int checked = 0;
    int n;
    pvbs_sequencer #(.VALID_CYC(VC), .HPD_DLY_CYC(HC)) dut (
        .core_clk_i(clk), .sys_rst_i(rst), .panel_logic_supply_i(sup),
        .black_disable_i(bdis), .video_valid_i(vv),
        .no_video_flag_i(nv | tflag), .link_idle_i(idl | tidl),
        .aux_req_i(req), .aux_rsp_o(rsp), .hpd_o(hpd),
        .black_video_o(blk));
    pvbs_source_model #(.GAP(GP)) src (
        .core_clk_i(clk), .sys_rst_i(rst), .run_i(run),
        .video_valid_o(vv), .no_video_flag_o(nv), .link_idle_o(idl),
        .bl_rail_o(), .bl_dim_o(), .bl_en_o(en));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic cmp(input logic [11:0] g, input logic [11:0] e);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // aux read: one-cycle request, answer taken while it stands
    task automatic rd(input logic [19:0] a, input logic [9:0] e);
        @(negedge clk);
        req = '{req: 1'b1, addr: a};
        @(negedge clk);
        cmp(12'(rsp), 12'(e));
        req = '0;
    endtask : rd
    task automatic wt(input bit h, input logic v, input int lim);
        n = 0;
        while (((h ? hpd : blk) !== v) && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= lim)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask : wt
    initial
    begin
        rst = 1'b1;
        sup = 1'b0;
        bdis = 1'b0;
        run = 1'b0;
        tflag = 1'b0;
        tidl = 1'b0;
        req = '0;
        repeat (20) @(negedge clk);
        cmp({hpd, blk, 10'(rsp)}, 12'h400);
        rst = 1'b0;
        sup = 1'b1;
        rd(SINK_STATUS_ADDR, 10'h100);
        wt(1'b1, 1'b1, HC + 8);
        cmp(12'((n + 2) inside {[HC:HC + SYNC_SLACK]}), 12'h1);
        cmp(12'(blk), 12'h1);
        rd(SINK_STATUS_ADDR, 10'h200);
        rd(20'h00206, 10'h200);
        run = 1'b1;
        wt(1'b0, 1'b0, VC + 8);
        cmp(12'(n inside {[VC:VC + 4]}), 12'h1);
        rd(SINK_STATUS_ADDR, 10'h201);
        tflag = 1'b1;
        repeat (2) @(negedge clk);
        cmp(12'(blk), 12'h1);
        rd(SINK_STATUS_ADDR, 10'h200);
        tflag = 1'b0;
        wt(1'b0, 1'b0, VC + 8);
        tidl = 1'b1;
        repeat (2) @(negedge clk);
        cmp(12'(blk), 12'h1);
        tidl = 1'b0;
        wt(1'b0, 1'b0, VC + 8);
        repeat (4 * GP) @(negedge clk);
        run = 1'b0;
        wt(1'b0, 1'b1, 5 * GP);
        cmp(12'(en), 12'h0);
        rd(SINK_STATUS_ADDR, 10'h200);
        bdis = 1'b1;
        repeat (5) @(negedge clk);
        cmp(12'(blk), 12'h0);
        bdis = 1'b0;
        sup = 1'b0;
        repeat (5) @(negedge clk);
        cmp({10'h0, hpd, blk}, 12'h1);
        wrap_up();
    end
endmodule : tb_top
